// ==== hdl/bus_port.sv ====
// slave handshake, slave select, data bus and dma master ready sampling
// assumes bus pins asynchronous to i_core_clk; tri-state resolved outside
// How it works
// - ready driven only during own slave cycle
// - isa long command: ready low from T2
// - never low for host or eisa master
// - low four bus clocks, then high
// - driver on at T2, off at command end
// - sample ready 2.5 clocks after non-idle
// - page break or end stops pipelining
// - sample ready each rising edge until idle
// - pipelined: sample until ready once more
// - reset floats ready pin
// - data driven on read or ack select
// - data input on writes, unused as master
// - reset floats data bus
// - select asserts at T2, never before
// - select released by command going inactive
// - select asserted on every interrupt acknowledge unless dma is master
// - select inactive high on reset, always driven
// - address enable low for dma or refresh
// - address enable inactive on reset
// - size status codes, both high idle
// - ack status low at T2 marks acknowledge
`default_nettype none
module bus_port (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // bus pins
    input wire bus_port_pkg::pins_t i_pins,
    // core side
    input wire bus_port_pkg::core_in_t i_core,
    // ready handshake pin
    output logic o_ready_handshake_out,
    output logic o_ready_handshake_oe,
    // slave select and data pins
    output logic o_slave_select_out_n,
    output logic [7:0] o_data_out,
    output logic o_data_oe,
    // master side pins
    output logic o_dma_owns_bus_n,
    output logic [1:0] o_transfer_size_status,
    // core side results
    output logic o_wr_strobe,
    output logic [7:0] o_wr_data,
    output logic [13:0] o_wr_addr,
    output logic o_pipelining,
    output logic o_dma_ready,
    output logic o_last_done
);
    import bus_port_pkg::*;

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic bclk_prev;
        logic cmd_prev;
        logic strobe_prev;
        logic [13:0] lat_addr;
        logic lat_mem_io;
        logic lat_wr_rd;
        slave_state_t slv;
        logic hit;
        logic int_ack;
        logic [2:0] rdy_cnt;
        logic rdy_out;
        logic rdy_oe;
        logic sel_n;
        logic [7:0] dout;
        logic doe;
        logic wr_strobe;
        logic [7:0] wr_data;
        logic [13:0] wr_addr;
        logic aen_n;
        logic [1:0] size;
        master_state_t mst;
        logic [2:0] half_cnt;
        logic pipe;
        logic pipe_seen;
        logic dma_ready;
        logic last_done;
    } state_t;

    state_t st;
    state_t next_st;
    logic bclk_rise;
    logic bclk_fall;
    logic cmd_rise;

    // register window decode for an i/o cycle with any byte enabled
    function automatic logic reg_hit(input logic [13:0] a, input logic mio, input logic [2:0] be_n);
        reg_hit = !mio && ((a & REG_MASK) == REG_BASE) && (be_n != BE_NONE);
    endfunction

    // one more bus clock edge counted; both edge counters share it
    function automatic logic [2:0] bump(input logic [2:0] c);
        bump = c + CNT_ONE;
    endfunction

    // ************************************************
    // edges of the synchronised pins
    // ************************************************
    // only the second flop stage feeds edge detection
    assign bclk_rise = st.s2.bclk && !st.bclk_prev;
    assign bclk_fall = !st.s2.bclk && st.bclk_prev;
    assign cmd_rise = st.s2.cmd_n && !st.cmd_prev;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.s1 = i_pins;
        next_st.s2 = st.s1;
        next_st.bclk_prev = st.s2.bclk;
        next_st.cmd_prev = st.s2.cmd_n;
        next_st.strobe_prev = st.s2.strobe;
        next_st.wr_strobe = 1'b0;
        next_st.dma_ready = 1'b0;
        next_st.last_done = 1'b0;
        // read data tracks the core every cycle, so it is valid on the first selected cycle
        next_st.dout = i_core.rd_data;
        next_st.aen_n = !(i_core.dma_owns || i_core.refresh);
        // trailing edge of the address strobe latches the cycle
        if (st.s2.strobe && !st.strobe_prev) begin
            next_st.lat_addr = st.s2.addr;
            next_st.lat_mem_io = st.s2.mem_io;
            next_st.lat_wr_rd = st.s2.wr_rd;
        end
        unique case (st.slv)
            S_IDLE: begin
                if (!st.s2.strobe && st.strobe_prev && i_core.master != MK_DMA) begin
                    next_st.slv = S_ARMED;
                end
            end
            S_ARMED: begin
                if (bclk_rise) begin
                    next_st.hit = reg_hit(st.lat_addr, st.lat_mem_io, st.s2.be_n);
                    next_st.int_ack = !st.s2.int_ack_status_n;
                    if (next_st.hit || next_st.int_ack) begin
                        next_st.slv = S_ACTIVE;
                        next_st.sel_n = 1'b0;
                        next_st.doe = next_st.int_ack || !st.lat_wr_rd;
                        // host and eisa masters end on their own timing
                        if (next_st.hit && !next_st.int_ack && i_core.master == MK_ISA
                            && i_core.isa_long_cmd) begin
                            next_st.rdy_oe = 1'b1;
                            next_st.rdy_out = 1'b0;
                            next_st.rdy_cnt = CNT_ZERO;
                        end
                    end else begin
                        next_st.slv = S_IDLE;
                    end
                end
            end
            S_ACTIVE: begin
                if (bclk_rise && !st.rdy_out) begin
                    next_st.rdy_cnt = bump(st.rdy_cnt);
                    if (bump(st.rdy_cnt) == READY_LOW_BCLKS) begin
                        next_st.rdy_out = 1'b1;
                    end
                end
                // release follows the command edge by the synchroniser delay
                if (cmd_rise) begin
                    next_st.slv = S_IDLE;
                    next_st.sel_n = 1'b1;
                    next_st.rdy_oe = 1'b0;
                    next_st.rdy_out = 1'b1;
                    next_st.doe = 1'b0;
                    if (st.hit && st.lat_wr_rd && !st.int_ack) begin
                        next_st.wr_strobe = 1'b1;
                        next_st.wr_data = st.s2.data;
                        next_st.wr_addr = st.lat_addr;
                    end
                end
            end
            default: next_st.slv = S_IDLE;
        endcase
        // ************************************************
        // dma master side
        // ************************************************
        if (bclk_fall) begin
            next_st.size = i_core.master == MK_DMA ? i_core.size : SIZE_IDLE;
        end
        if (bclk_rise && st.pipe && (i_core.page_break || i_core.xfer_end)) begin
            next_st.pipe = 1'b0;
        end
        unique case (st.mst)
            M_IDLE: begin
                next_st.pipe = 1'b0;
                next_st.pipe_seen = 1'b0;
                if (bclk_fall && st.size == SIZE_IDLE && next_st.size != SIZE_IDLE) begin
                    next_st.mst = M_WAIT;
                    next_st.half_cnt = CNT_ZERO;
                end
            end
            M_WAIT: begin
                if (bclk_rise || bclk_fall) begin
                    next_st.half_cnt = bump(st.half_cnt);
                    if (bump(st.half_cnt) == PIPE_SAMPLE_HALVES) begin
                        // a page break on the sample edge itself keeps pipelining off
                        next_st.pipe = st.s2.ready && !(i_core.page_break || i_core.xfer_end);
                        next_st.pipe_seen = next_st.pipe;
                        next_st.mst = M_RUN;
                    end
                end
            end
            M_RUN: begin
                if (bclk_rise) begin
                    if (st.size == SIZE_IDLE) begin
                        next_st.mst = st.pipe_seen ? M_DRAIN : M_IDLE;
                    end else begin
                        next_st.dma_ready = st.s2.ready;
                    end
                end
            end
            M_DRAIN: begin
                if (bclk_rise && st.s2.ready) begin
                    next_st.last_done = 1'b1;
                    next_st.mst = M_IDLE;
                end
            end
        endcase
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st <= '0;
            st.slv <= S_IDLE;
            st.mst <= M_IDLE;
            st.rdy_out <= 1'b1;
            st.rdy_oe <= 1'b0;
            st.doe <= 1'b0;
            st.sel_n <= 1'b1;
            st.aen_n <= 1'b1;
            st.size <= SIZE_IDLE;
            st.s1.cmd_n <= 1'b1;
            st.s2.cmd_n <= 1'b1;
            st.cmd_prev <= 1'b1;
            st.s1.strobe <= 1'b1;
            st.s2.strobe <= 1'b1;
            st.strobe_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_ready_handshake_out = st.rdy_out;
    assign o_ready_handshake_oe = st.rdy_oe;
    assign o_slave_select_out_n = st.sel_n;
    assign o_data_out = st.dout;
    assign o_data_oe = st.doe;
    assign o_dma_owns_bus_n = st.aen_n;
    assign o_transfer_size_status = st.size;
    assign o_wr_strobe = st.wr_strobe;
    assign o_wr_data = st.wr_data;
    assign o_wr_addr = st.wr_addr;
    assign o_pipelining = st.pipe;
    assign o_dma_ready = st.dma_ready;
    assign o_last_done = st.last_done;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    sequence t2_edge;
        st.slv == S_ARMED && bclk_rise;
    endsequence
    sequence cmd_release;
        st.slv == S_ACTIVE && cmd_rise;
    endsequence
    sequence isa_long_hit;
        reg_hit(st.lat_addr, st.lat_mem_io, st.s2.be_n) && st.s2.int_ack_status_n
            && i_core.master == MK_ISA && i_core.isa_long_cmd;
    endsequence
    sequence plain_miss;
        !reg_hit(st.lat_addr, st.lat_mem_io, st.s2.be_n) && st.s2.int_ack_status_n;
    endsequence

    // ************************************************
    // slave side checks, then address enable, pipelining stop, last cycle done and reset checks
    // ************************************************
    ready_t2_a: assert property (t2_edge ##0 isa_long_hit |=> o_ready_handshake_oe && !o_ready_handshake_out)
        else $error("ready not driven low at T2");
    ready_park_a: assert property (!o_ready_handshake_oe |-> o_ready_handshake_out)
        else $error("ready parked low while released");
    miss_quiet_a: assert property (t2_edge ##0 plain_miss |=> o_slave_select_out_n && !o_ready_handshake_oe)
        else $error("select on a decode miss");
    ack_data_a: assert property (t2_edge ##0 !st.s2.int_ack_status_n |=> o_data_oe)
        else $error("acknowledge data not driven");
    write_in_a: assert property (t2_edge ##0 st.lat_wr_rd && st.s2.int_ack_status_n |=> !o_data_oe)
        else $error("data driven on a write");
    write_strobe_a: assert property (o_wr_strobe |-> $past(st.slv) == S_ACTIVE
        && $past(cmd_rise) && !$past(o_data_oe))
        else $error("register write outside a write cycle");
    dma_no_select_a: assert property (i_core.master == MK_DMA && st.slv == S_IDLE |=> o_slave_select_out_n)
        else $error("select while dma is master");

    sel_at_t2_a: assert property ($fell(o_slave_select_out_n) |-> $past(st.slv) == S_ARMED)
        else $error("select asserted outside T2");
    ready_isa_only_a: assert property ($rose(o_ready_handshake_oe) |-> $past(i_core.master) == MK_ISA)
        else $error("ready driven for non isa master");
    ready_in_cycle_a: assert property (o_ready_handshake_oe |-> !o_slave_select_out_n)
        else $error("ready driven outside slave cycle");
    data_oe_sel_a: assert property (o_data_oe |-> !o_slave_select_out_n && st.slv == S_ACTIVE)
        else $error("data driven without select");
    ready_low_len_a: assert property (o_ready_handshake_oe && !o_ready_handshake_out |-> st.rdy_cnt < 3'h4)
        else $error("ready held low too long");
    ready_high_a: assert property (!o_ready_handshake_out && o_ready_handshake_oe && bclk_rise
        && st.rdy_cnt == 3'h3 && !cmd_rise |=> o_ready_handshake_out && o_ready_handshake_oe)
        else $error("ready not released after four clocks");
    release_a: assert property (cmd_release |=> o_slave_select_out_n && !o_ready_handshake_oe && !o_data_oe)
        else $error("select not released on command end");
    ack_select_a: assert property (t2_edge ##0 !st.s2.int_ack_status_n |=> !o_slave_select_out_n)
        else $error("interrupt acknowledge not selected");
    aen_a: assert property ((i_core.dma_owns || i_core.refresh) |=> !o_dma_owns_bus_n)
        else $error("address enable not active");
    pipe_stop_a: assert property (bclk_rise && (i_core.page_break || i_core.xfer_end) |=> !o_pipelining)
        else $error("pipelining not stopped");
    last_done_a: assert property (o_last_done |-> $past(st.mst) == M_DRAIN && $past(st.s2.ready))
        else $error("last cycle done without ready");
    reset_a: assert property (disable iff (1'b0) i_srst |=> o_slave_select_out_n && !o_ready_handshake_oe
        && !o_data_oe && o_dma_owns_bus_n)
        else $error("reset state wrong");

    // ************************************************
    // master side checks
    // ************************************************
    pipe_start_a: assert property ($rose(o_pipelining) |-> $past(st.mst) == M_WAIT && $past(st.s2.ready))
        else $error("pipelining started without ready");
    dma_ready_a: assert property (o_dma_ready |-> $past(st.mst) == M_RUN
        && $past(bclk_rise) && $past(st.s2.ready))
        else $error("dma ready pulse without a sample");
    size_edge_a: assert property ($changed(o_transfer_size_status) |-> $past(bclk_fall))
        else $error("size status moved off a falling edge");
    drain_piped_a: assert property (st.mst == M_DRAIN |-> st.pipe_seen)
        else $error("final ready wait without pipelining");
    aen_idle_a: assert property (!(i_core.dma_owns || i_core.refresh) |=> o_dma_owns_bus_n)
        else $error("address enable active without dma or refresh");
endmodule
`default_nettype wire

// ==== hdl/bus_port_pkg.sv ====
// types and constants for the system bus slave/master handshake block
// assumes one core clock; every bus pin arrives asynchronous to it
`default_nettype none
package bus_port_pkg;
    // ************************************************
    // timing counts, in bus clock edges
    // ************************************************
    localparam logic [2:0] READY_LOW_BCLKS = 3'h4;
    localparam logic [2:0] PIPE_SAMPLE_HALVES = 3'h5;
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_ONE = 3'h1;
    // ************************************************
    // transfer size status encodings
    // ************************************************
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;
    localparam logic [1:0] SIZE_IDLE = 2'h3;
    // ************************************************
    // register window decode and reset values
    // ************************************************
    localparam logic [13:0] REG_BASE = 14'h0000;
    localparam logic [13:0] REG_MASK = 14'h3fc0;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [13:0] ADDR_ZERO = 14'h0000;
    localparam logic [2:0] BE_NONE = 3'h7;

    typedef enum logic [1:0] {MK_HOST, MK_EISA, MK_ISA, MK_DMA} master_kind_t;
    typedef enum logic [1:0] {S_IDLE, S_ARMED, S_ACTIVE} slave_state_t;
    typedef enum logic [1:0] {M_IDLE, M_WAIT, M_RUN, M_DRAIN} master_state_t;

    // bus pins, as seen after synchronising
    typedef struct packed {
        logic bclk;
        logic cmd_n;
        logic strobe;
        logic int_ack_status_n;
        logic ready;
        logic mem_io;
        logic wr_rd;
        logic [2:0] be_n;
        logic [13:0] addr;
        logic [7:0] data;
    } pins_t;

    // inputs from the dma controller and arbiter core
    typedef struct packed {
        master_kind_t master;
        logic isa_long_cmd;
        logic dma_owns;
        logic refresh;
        logic [1:0] size;
        logic page_break;
        logic xfer_end;
        logic [7:0] rd_data;
    } core_in_t;
endpackage
`default_nettype wire

// ==== tb/bus_partner.sv ====
// bus controller model: free-running bus clock, slave cycles, released ready set from the bench level
// assumes the bench calls slave_cycle and sets the master-side ready level
`default_nettype none
module bus_partner (
    // device pins
    input wire logic i_ready_out,
    input wire logic i_ready_oe,
    input wire logic [7:0] i_data_out,
    input wire logic i_data_oe,
    // bench control
    input wire logic i_dma_ready,
    output var bus_port_pkg::pins_t o_pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import bus_port_pkg::*;
    // ************
    // pin drive
    // ************
    logic bclk = 1'b0;
    logic t2_seen = 1'b0;
    logic host_drv = 1'b0;
    logic [7:0] wr_val = 8'h00;
    pins_t drv = '1;
    // bus clock runs free; edges fall on 64 ns steps, on core falling edges, never on a rising one
    always #64 bclk = ~bclk;
    always_comb begin
        o_pins = drv;
        o_pins.bclk = bclk;
        o_pins.ready = i_ready_oe ? i_ready_out : i_dma_ready;
        // a released data line shows the inverse of the last value
        o_pins.data = i_data_oe ? i_data_out : (host_drv ? wr_val : ~wr_val);
    end
    task automatic slave_cycle(input logic wr, input logic ack_n, input logic [13:0] a, input logic [7:0] d);
        @(negedge bclk);
        #4;
        t2_seen = 1'b0;
        drv.addr = a;
        drv.wr_rd = wr;
        drv.mem_io = 1'b0;
        drv.be_n = 3'h0;
        drv.int_ack_status_n = ack_n;
        drv.strobe = 1'b0;
        wr_val = d;
        host_drv = wr;
        #32 drv.strobe = 1'b1;
        @(posedge bclk);
        t2_seen = 1'b1;
        #4 drv.cmd_n = 1'b0;
        repeat (6) @(posedge bclk);
        #4 drv.cmd_n = 1'b1;
        #40 drv = '1;
        host_drv = 1'b0;
        repeat (2) @(posedge bclk);
    endtask
endmodule
`default_nettype wire

// ==== tb/system_bus_slave_master_handshake_tb_top.sv ====
// self-checking bench for bus_port against the bus controller model
// assumes a 250 MHz core clock and a bus clock of 128 ns (32 core cycles)
`default_nettype none
module system_bus_slave_master_handshake_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import bus_port_pkg::*;
    // ************
    // harness
    // ************
    typedef enum int {C_SEL, C_EARLY, C_LOW, C_HI, C_DOE, C_DBAD, C_WR, C_RDY, C_LAST} cnt_idx_t;
    logic i_core_clk, i_srst, dma_rdy, ready_out, ready_oe, sel_n, data_oe, owns_n;
    logic wr_strobe, piping, dma_ready, last_done;
    logic [7:0] data_out, wr_data;
    logic [13:0] wr_addr;
    logic [1:0] size_st;
    pins_t pins;
    core_in_t core;
    int num_errors = 0;
    int checks_done = 0;
    int n[9];
    bus_port bus_port_i (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_pins(pins), .i_core(core),
        .o_ready_handshake_out(ready_out), .o_ready_handshake_oe(ready_oe), .o_slave_select_out_n(sel_n),
        .o_data_out(data_out), .o_data_oe(data_oe), .o_dma_owns_bus_n(owns_n), .o_transfer_size_status(size_st),
        .o_wr_strobe(wr_strobe), .o_wr_data(wr_data), .o_wr_addr(wr_addr), .o_pipelining(piping),
        .o_dma_ready(dma_ready), .o_last_done(last_done));
    bus_partner bus_partner_i (.i_ready_out(ready_out), .i_ready_oe(ready_oe), .i_data_out(data_out),
        .i_data_oe(data_oe), .i_dma_ready(dma_rdy), .o_pins(pins));
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        if (sel_n === 1'b0) n[C_SEL]++;
        if (sel_n === 1'b0 && !bus_partner_i.t2_seen) n[C_EARLY]++;
        if (ready_oe === 1'b1 && ready_out === 1'b0) n[C_LOW]++;
        if (ready_oe === 1'b1 && ready_out === 1'b1) n[C_HI]++;
        if (data_oe === 1'b1) n[C_DOE]++;
        if (data_oe === 1'b1 && data_out !== core.rd_data) n[C_DBAD]++;
        if (wr_strobe === 1'b1) n[C_WR]++;
        if (dma_ready === 1'b1) n[C_RDY]++;
        if (last_done === 1'b1) n[C_LAST]++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h range=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask
    task automatic slave(input master_kind_t m, input logic wr, input logic ack_n, input logic [13:0] a);
        cyc(1);
        core.master = m;
        n = '{default: 0};
        bus_partner_i.slave_cycle(wr, ack_n, a, 8'h5a);
        cyc(4);
        chk({13'h0000, ready_oe, sel_n, data_oe}, 16'h0002);
        chk_in(n[C_EARLY], 0, 0);
    endtask
    // ************
    // scenarios
    // ************
    task automatic t_isa_read();
        slave(MK_ISA, 1'b0, 1'b1, 14'h0010);
        chk_in(n[C_LOW], 126, 130);
        chk_in(n[C_HI], 1, 200);
        chk_in(n[C_SEL], 1, 400);
        chk_in(n[C_DOE], 1, 400);
        chk_in(n[C_DBAD], 0, 0);
        $display("test isa_read done");
    endtask
    task automatic t_other_masters();
        master_kind_t ms[2] = '{MK_HOST, MK_EISA};
        foreach (ms[i]) begin
            slave(ms[i], 1'b0, 1'b1, 14'h0004);
            chk_in(n[C_LOW], 0, 0);
            chk_in(n[C_HI], 0, 0);
            chk_in(n[C_SEL], 1, 400);
        end
        core.isa_long_cmd = 1'b0;
        slave(MK_ISA, 1'b0, 1'b1, 14'h0008);
        chk_in(n[C_LOW] + n[C_HI], 0, 0);
        chk_in(n[C_SEL], 1, 400);
        core.isa_long_cmd = 1'b1;
        $display("test other_masters done");
    endtask
    task automatic t_miss_ack();
        slave(MK_ISA, 1'b0, 1'b1, 14'h0040);
        chk_in(n[C_SEL] + n[C_LOW] + n[C_HI] + n[C_DOE], 0, 0);
        slave(MK_HOST, 1'b0, 1'b0, 14'h0040);
        chk_in(n[C_SEL], 1, 400);
        chk_in(n[C_DOE], 1, 400);
        chk_in(n[C_DBAD] + n[C_LOW], 0, 0);
        $display("test miss_ack done");
    endtask
    task automatic t_write();
        slave(MK_ISA, 1'b1, 1'b1, 14'h0025);
        chk_in(n[C_DOE], 0, 0);
        chk_in(n[C_WR], 1, 1);
        chk({8'h00, wr_data}, 16'h005a);
        chk({2'b00, wr_addr}, 16'h0025);
        $display("test write done");
    endtask
    task automatic t_dma();
        logic [1:0] sz[3] = '{SIZE_8, SIZE_16, SIZE_32};
        core.master = MK_DMA;
        core.dma_owns = 1'b1;
        core.size = SIZE_16;
        cyc(200);
        chk({15'h0000, piping}, 16'h0001);
        chk({15'h0000, owns_n}, 16'h0000);
        n = '{default: 0};
        cyc(256);
        chk_in(n[C_RDY], 7, 9);
        core.page_break = 1'b1;
        cyc(40);
        chk({15'h0000, piping}, 16'h0000);
        core.page_break = 1'b0;
        foreach (sz[i]) begin
            core.size = sz[i];
            cyc(40);
            chk({14'h0000, size_st}, {14'h0000, sz[i]});
        end
        dma_rdy = 1'b0;
        core.size = SIZE_IDLE;
        n = '{default: 0};
        cyc(100);
        chk_in(n[C_LAST], 0, 0);
        chk({14'h0000, size_st}, {14'h0000, SIZE_IDLE});
        dma_rdy = 1'b1;
        cyc(80);
        chk_in(n[C_LAST], 1, 1);
        core.master = MK_HOST;
        for (int i = 0; i < 4; i++) begin
            {core.dma_owns, core.refresh} = 2'(i);
            cyc(4);
            chk({15'h0000, owns_n}, {15'h0000, i == 0});
        end
        $display("test dma done");
    endtask
    task automatic close_out();
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        num_errors++;
        close_out();
    end
    initial begin
        i_srst = 1'b1;
        dma_rdy = 1'b1;
        core = '0;
        core.master = MK_HOST;
        core.isa_long_cmd = 1'b1;
        core.size = SIZE_IDLE;
        core.rd_data = 8'hc3;
        cyc(5);
        chk({9'h000, ready_oe, ready_out, sel_n, data_oe, owns_n, size_st}, 16'h0037);
        cyc(1);
        i_srst = 1'b0;
        cyc(10);
        t_isa_read();
        t_other_masters();
        t_miss_ack();
        t_write();
        t_dma();
        close_out();
    end
endmodule
`default_nettype wire
